/* pkg/dwfcd_regs.svh */
/*
 * Opcodes, byte counts and timing defaults of the two-wire decoder.
 * Assumes inclusion by bare name from the core.
 */
`ifndef DWFCD_REGS_SVH
`define DWFCD_REGS_SVH

`define DWFCD_OP_ID_RD        8'hAF
`define DWFCD_OP_PARAM_RD     8'h5A
`define DWFCD_OP_FAST_RD_A    8'h0B
`define DWFCD_OP_FAST_RD_B    8'h3B
`define DWFCD_OP_FAST_RD_C    8'hBB
`define DWFCD_OP_OTP_RD       8'h4B
`define DWFCD_OP_LATCH_SET    8'h06
`define DWFCD_OP_LATCH_CLR    8'h04
`define DWFCD_OP_PROG_A       8'h02
`define DWFCD_OP_PROG_B       8'hA2
`define DWFCD_OP_PROG_C       8'hD2
`define DWFCD_OP_OTP_PROG     8'h42
`define DWFCD_OP_SMALL_ERASE  8'h20
`define DWFCD_OP_BLOCK_ERASE  8'hD8
`define DWFCD_OP_WHOLE_ERASE  8'hC7
`define DWFCD_OP_RESUME       8'h7A
`define DWFCD_OP_SUSPEND      8'h75
`define DWFCD_OP_STATUS_RD    8'h05
`define DWFCD_OP_STATUS_WR    8'h01
`define DWFCD_OP_LOCK_RD      8'hE8
`define DWFCD_OP_LOCK_WR      8'hE5
`define DWFCD_OP_FLAG_RD      8'h70
`define DWFCD_OP_FLAG_CLR     8'h50
`define DWFCD_OP_NVCFG_RD     8'hB5
`define DWFCD_OP_NVCFG_WR     8'hB1
`define DWFCD_OP_VCFG_RD      8'h85
`define DWFCD_OP_VCFG_WR      8'h81
`define DWFCD_OP_ECFG_RD      8'h65
`define DWFCD_OP_ECFG_WR      8'h61
`define DWFCD_OP_SLEEP_ENTER  8'hB9
`define DWFCD_OP_SLEEP_EXIT   8'hAB

// byte counts; an out limit of zero means unbounded
`define DWFCD_ADDR_BYTES      2'h3
`define DWFCD_ID_BYTES        9'h003
`define DWFCD_NVCFG_BYTES     9'h002
`define DWFCD_OTP_BYTES       9'h041
`define DWFCD_PAGE_BYTES      9'h100
`define DWFCD_UNBOUNDED       9'h000
`define DWFCD_DUMMY_DEFAULT   4'h8

`endif

/* pkg/dwfcd_pkg.sv */
/*
 * Types of the two-wire flash instruction decoder.
 * Assumes the core includes dwfcd_regs.svh for the numeric constants.
 */
package dwfcd_pkg;

   typedef enum logic [4:0] {
      K_NONE, K_DUAL_ID_READ, K_PARAM_AREA_READ, K_DUAL_FAST_READ,
      K_OTP_READ, K_WRITE_LATCH_SET, K_WRITE_LATCH_CLEAR,
      K_DUAL_PAGE_PROGRAM, K_OTP_PROGRAM, K_SMALL_BLOCK_ERASE,
      K_BLOCK_ERASE, K_WHOLE_ARRAY_ERASE, K_MODIFY_RESUME,
      K_MODIFY_SUSPEND, K_STATUS_READ, K_STATUS_WRITE, K_LOCK_READ,
      K_LOCK_WRITE, K_FLAG_STATUS_READ, K_FLAG_STATUS_CLEAR,
      K_NONVOLATILE_CFG_READ, K_NONVOLATILE_CFG_WRITE,
      K_VOLATILE_CFG_READ, K_VOLATILE_CFG_WRITE, K_ENHANCED_CFG_READ,
      K_ENHANCED_CFG_WRITE, K_SLEEP_ENTER, K_SLEEP_EXIT
   } dwfcd_kind_t;

   typedef enum logic [2:0] {
      ST_OPCODE, ST_INPUT, ST_DUMMY, ST_OUTPUT, ST_SKIP
   } dwfcd_state_t;

   // decoded shape of one instruction
   typedef struct packed {
      dwfcd_kind_t kind;
      logic [1:0] addr_n;
      logic dummy;
      logic out;
      logic poll;
      logic needs_latch;
      logic [8:0] tot_min;
      logic [8:0] tot_max;
      logic [8:0] out_max;
   } dwfcd_info_t;

   // accepted instruction, issued once at deselection
   typedef struct packed {
      logic valid;
      dwfcd_kind_t kind;
      logic [23:0] addr;
   } dwfcd_exec_t;

   // one byte received after the address
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } dwfcd_wr_t;

   // request for the next byte to be shifted out
   typedef struct packed {
      logic valid;
      dwfcd_kind_t kind;
      logic [23:0] addr;
   } dwfcd_rd_t;

endpackage

/* core/dwfcd_core.sv */
/*
 * Two-wire serial flash instruction decoder and transfer sequencer.
 * Assumes serial clock, chip select and data lines are async pins and the
 * serial clock is far slower than clock.
 */
// Function
// R01: identification read AFh, no address or dummy, one to three bytes out.
// R02: identity is manufacturer then two device bytes, never unique_identifier.
// R03: opcode enters two bits per clock on both lines, four clocks.
// R04: output drives two bits per clock, changing on serial clock falls.
// R05: identification read during program or erase is ignored, no effect.
// R06: chip select rise ends identification output; device returns to standby.
// R07: parameter read 5Ah, three address bytes, eight dummy clocks, unbounded data.
// R08: parameter read opcode, address and data all travel two bits per clock.
// R09: dummy clocks counted plainly, never compressed; host sends full count.
// R10: dummy clock count comes from a user setting, default eight.
// R11: fast read accepted as 0Bh, 3Bh or BBh identically.
// R12: fast read opcode, address and data all two bits per clock.
// R13: page program 02h, A2h or D2h, three address bytes, 1 to 256 data.
// R14: flag status read 70h, no address, data until deselected.
// R15: flag status clear 50h, no address, dummy or data.
// R16: nonvolatile config read B5h returns exactly two bytes.
// R17: nonvolatile config write B1h takes exactly two data bytes.
// R18: volatile config read 85h streams data until deselected.
// R19: volatile config write 81h takes one data byte.
// R20: enhanced config read 65h streams, write 61h takes one byte.
// R21: sleep exit ABh has no address, dummy or data.
// R22: lock write E5h, three address bytes then exactly one data byte.
// R23: remaining tabulated opcodes recognised with their counts; unknown ones ignored.
// R24: write-type instructions execute only if deselected on a byte boundary.
// R25: read instructions may end after any output bit; driving stops.
// R26: program and register writes need the write_permit_latch set beforehand.
`timescale 1ns/1ps

module dwfcd_core
   import dwfcd_pkg::*;
#(
   parameter logic [23:0] ID_VALUE = 24'h5A3C96 // arbitrary identity value
)(
   input wire logic clock, // system clock, 125 MHz
   input wire logic rstn, // synchronous reset, active low
   input wire logic sclk_pin, // serial clock from host
   input wire logic cs_n_pin, // chip select from host, active low
   input wire logic data_line_zero_i, // data line zero level
   input wire logic data_line_one_i, // data line one level
   output logic data_line_zero_o, // data line zero drive value
   output logic data_line_one_o, // data line one drive value
   output logic data_line_oe, // both data lines driven when high
   input wire logic modify_busy, // program or erase cycle running
   input wire logic [3:0] dummy_cfg, // configured dummy clock count
   input wire logic [7:0] src_data, // byte answering the last request
   output dwfcd_rd_t rd_req, // next output byte wanted
   output dwfcd_wr_t wr_byte, // input data byte received
   output dwfcd_exec_t exec, // accepted instruction at deselection
   output logic write_permit_latch, // write permit latch state
   output logic asleep // sleep mode state
);
`include "dwfcd_regs.svh"
////////////////////////////////////////////////////////////////////////////
// opcode decoding
function automatic dwfcd_info_t mk(input dwfcd_kind_t k,
   input logic [1:0] an, input logic dm, input logic ot, input logic pl,
   input logic lt, input logic [8:0] mn, input logic [8:0] mx,
   input logic [8:0] om);
   return '{k, an, dm, ot, pl, lt, mn, mx, om};
endfunction
function automatic dwfcd_info_t decode(input logic [7:0] op);
   localparam logic [1:0] A3 = `DWFCD_ADDR_BYTES;
   localparam logic [8:0] N0 = 9'h000;
   localparam logic [8:0] N1 = 9'h001;
   localparam logic [8:0] N2 = `DWFCD_NVCFG_BYTES;
   localparam logic [8:0] N3 = 9'h003;
   localparam logic [8:0] N4 = 9'h004;
   localparam logic [8:0] UB = `DWFCD_UNBOUNDED;
   dwfcd_info_t i;
   i = mk(K_NONE, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, N0, N0, UB);
   case (op)
      `DWFCD_OP_ID_RD: i = mk(K_DUAL_ID_READ, 2'h0, 1'b0, 1'b1, 1'b0,
         1'b0, N0, N0, `DWFCD_ID_BYTES); // R01
      `DWFCD_OP_PARAM_RD: i = mk(K_PARAM_AREA_READ, A3, 1'b1, 1'b1, 1'b0,
         1'b0, N3, N3, UB); // R07
      `DWFCD_OP_FAST_RD_A, `DWFCD_OP_FAST_RD_B, `DWFCD_OP_FAST_RD_C:
         i = mk(K_DUAL_FAST_READ, A3, 1'b1, 1'b1, 1'b0, 1'b0, N3, N3,
            UB); // R11
      `DWFCD_OP_OTP_RD: i = mk(K_OTP_READ, A3, 1'b1, 1'b1, 1'b0, 1'b0, N3,
         N3, `DWFCD_OTP_BYTES); // R23
      `DWFCD_OP_LATCH_SET: i.kind = K_WRITE_LATCH_SET; // R23
      `DWFCD_OP_LATCH_CLR: i.kind = K_WRITE_LATCH_CLEAR; // R23
      `DWFCD_OP_PROG_A, `DWFCD_OP_PROG_B, `DWFCD_OP_PROG_C:
         i = mk(K_DUAL_PAGE_PROGRAM, A3, 1'b0, 1'b0, 1'b0, 1'b1, N4,
            9'(N3 + `DWFCD_PAGE_BYTES), UB); // R13
      `DWFCD_OP_OTP_PROG: i = mk(K_OTP_PROGRAM, A3, 1'b0, 1'b0, 1'b0, 1'b1,
         N4, 9'(N3 + `DWFCD_OTP_BYTES), UB); // R23
      `DWFCD_OP_SMALL_ERASE: i = mk(K_SMALL_BLOCK_ERASE, A3, 1'b0, 1'b0,
         1'b0, 1'b1, N3, N3, UB); // R23
      `DWFCD_OP_BLOCK_ERASE: i = mk(K_BLOCK_ERASE, A3, 1'b0, 1'b0, 1'b0,
         1'b1, N3, N3, UB); // R23
      `DWFCD_OP_WHOLE_ERASE: i = mk(K_WHOLE_ARRAY_ERASE, 2'h0, 1'b0, 1'b0,
         1'b0, 1'b1, N0, N0, UB); // R23
      `DWFCD_OP_RESUME: i = mk(K_MODIFY_RESUME, 2'h0, 1'b0, 1'b0, 1'b1,
         1'b0, N0, N0, UB); // R23
      `DWFCD_OP_SUSPEND: i = mk(K_MODIFY_SUSPEND, 2'h0, 1'b0, 1'b0, 1'b1,
         1'b0, N0, N0, UB); // R23
      `DWFCD_OP_STATUS_RD: i = mk(K_STATUS_READ, 2'h0, 1'b0, 1'b1, 1'b1,
         1'b0, N0, N0, UB); // R23
      `DWFCD_OP_STATUS_WR: i = mk(K_STATUS_WRITE, 2'h0, 1'b0, 1'b0, 1'b0,
         1'b1, N1, N1, UB); // R23
      `DWFCD_OP_LOCK_RD: i = mk(K_LOCK_READ, A3, 1'b0, 1'b1, 1'b0, 1'b0,
         N3, N3, UB); // R23
      `DWFCD_OP_LOCK_WR: i = mk(K_LOCK_WRITE, A3, 1'b0, 1'b0, 1'b0, 1'b1,
         N4, N4, UB); // R22
      `DWFCD_OP_FLAG_RD: i = mk(K_FLAG_STATUS_READ, 2'h0, 1'b0, 1'b1, 1'b1,
         1'b0, N0, N0, UB); // R14
      `DWFCD_OP_FLAG_CLR: i.kind = K_FLAG_STATUS_CLEAR; // R15
      `DWFCD_OP_NVCFG_RD: i = mk(K_NONVOLATILE_CFG_READ, 2'h0, 1'b0, 1'b1,
         1'b0, 1'b0, N0, N0, `DWFCD_NVCFG_BYTES); // R16
      `DWFCD_OP_NVCFG_WR: i = mk(K_NONVOLATILE_CFG_WRITE, 2'h0, 1'b0, 1'b0,
         1'b0, 1'b1, N2, N2, UB); // R17
      `DWFCD_OP_VCFG_RD: i = mk(K_VOLATILE_CFG_READ, 2'h0, 1'b0, 1'b1,
         1'b0, 1'b0, N0, N0, UB); // R18
      `DWFCD_OP_VCFG_WR: i = mk(K_VOLATILE_CFG_WRITE, 2'h0, 1'b0, 1'b0,
         1'b0, 1'b1, N1, N1, UB); // R19
      `DWFCD_OP_ECFG_RD: i = mk(K_ENHANCED_CFG_READ, 2'h0, 1'b0, 1'b1,
         1'b0, 1'b0, N0, N0, UB); // R20
      `DWFCD_OP_ECFG_WR: i = mk(K_ENHANCED_CFG_WRITE, 2'h0, 1'b0, 1'b0,
         1'b0, 1'b1, N1, N1, UB); // R20
      `DWFCD_OP_SLEEP_ENTER: i.kind = K_SLEEP_ENTER; // R23
      `DWFCD_OP_SLEEP_EXIT: i.kind = K_SLEEP_EXIT; // R21
      default: i.kind = K_NONE; // R23
   endcase
   return i;
endfunction
////////////////////////////////////////////////////////////////////////////
// pin synchronisers and serial clock edges
logic [3:0] pin_raw, sync1_reg, sync2_reg;
logic sclk_prev_reg, cs_prev_reg;
assign pin_raw = {data_line_one_i, data_line_zero_i, cs_n_pin, sclk_pin};
genvar g;
generate
   for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clock) begin
         if (!rstn) begin
            sync1_reg[g] <= 1'b0;
            sync2_reg[g] <= g == 1 ? 1'b1 : 1'b0;
         end else begin
            sync1_reg[g] <= pin_raw[g];
            sync2_reg[g] <= sync1_reg[g];
         end
      end
   end
endgenerate
always_ff @(posedge clock) begin
   if (!rstn) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
   end else begin
      sclk_prev_reg <= sync2_reg[0];
      cs_prev_reg <= sync2_reg[1];
   end
end
logic selected, sclk_rise, sclk_fall, cs_rise;
logic [1:0] dibit_in;
assign selected = !sync2_reg[1];
assign sclk_rise = selected && sync2_reg[0] && !sclk_prev_reg;
assign sclk_fall = selected && !sync2_reg[0] && sclk_prev_reg;
assign cs_rise = sync2_reg[1] && !cs_prev_reg;
assign dibit_in = sync2_reg[3:2];
////////////////////////////////////////////////////////////////////////////
// input sequencing on rising serial clock
dwfcd_state_t state_reg;
dwfcd_info_t info_reg, info_new;
logic [7:0] shift_reg, byte_in;
logic [1:0] dib_reg;
logic [8:0] in_bytes_reg;
logic [3:0] dummy_reg;
logic [23:0] addr_reg;
logic byte_done, accept;
assign byte_in = {shift_reg[5:0], dibit_in}; // R03
assign byte_done = dib_reg == 2'h3;
assign info_new = decode(byte_in);
// while busy only polling and suspend/resume get through
assign accept = info_new.kind != K_NONE
   && (!asleep || info_new.kind == K_SLEEP_EXIT)
   && (!modify_busy || info_new.poll); // R05
always_ff @(posedge clock) begin
   if (!rstn || !selected) begin
      state_reg <= ST_OPCODE;
      dib_reg <= 2'h0;
      in_bytes_reg <= 9'h000;
      dummy_reg <= 4'h0;
   end else if (sclk_rise) begin
      dib_reg <= 2'(dib_reg + 2'h1);
      case (state_reg)
         ST_OPCODE: begin
            if (byte_done) begin
               if (!accept) begin
                  state_reg <= ST_SKIP; // R23
               end else if (info_new.out && info_new.addr_n == 2'h0) begin
                  state_reg <= ST_OUTPUT;
               end else begin
                  state_reg <= ST_INPUT;
               end
            end
         end
         ST_INPUT: begin
            if (byte_done) begin
               if (in_bytes_reg != 9'h1FF) begin
                  in_bytes_reg <= 9'(in_bytes_reg + 9'h001);
               end
               if (info_reg.out
                     && in_bytes_reg[1:0] == 2'(info_reg.addr_n - 2'h1)) begin
                  // dummy clocks are plain clocks, one per count
                  if (info_reg.dummy && dummy_cfg != 4'h0) begin
                     state_reg <= ST_DUMMY; // R09
                  end else begin
                     state_reg <= ST_OUTPUT; // R08 R12
                  end
               end
            end
         end
         ST_DUMMY: begin
            dummy_reg <= 4'(dummy_reg + 4'h1);
            if (4'(dummy_reg + 4'h1) == dummy_cfg) begin
               state_reg <= ST_OUTPUT; // R10
            end
         end
         default: state_reg <= state_reg;
      endcase
   end
end

always_ff @(posedge clock) begin
   if (!rstn) begin
      shift_reg <= 8'h00;
      info_reg <= decode(8'h00);
      addr_reg <= 24'h000000;
   end else if (selected && sclk_rise) begin
      shift_reg <= byte_in;
      if (state_reg == ST_OPCODE && byte_done) begin
         info_reg <= info_new;
         addr_reg <= 24'h000000;
      end else if (state_reg == ST_INPUT && byte_done
            && in_bytes_reg < 9'(info_reg.addr_n)) begin
         addr_reg <= {addr_reg[15:0], byte_in};
      end
   end else if (rd_req.valid) begin
      addr_reg <= 24'(addr_reg + 24'h000001);
   end
end

always_ff @(posedge clock) begin
   if (!rstn) begin
      wr_byte <= '0;
   end else begin
      wr_byte.valid <= selected && sclk_rise && state_reg == ST_INPUT
         && byte_done && !info_reg.out
         && in_bytes_reg >= 9'(info_reg.addr_n);
      wr_byte.data <= byte_in;
   end
end

////////////////////////////////////////////////////////////////////////////
// output sequencing on falling serial clock
logic [7:0] out_sh_reg, id_byte, out_byte, out_next;
logic [1:0] ocnt_reg;
logic [8:0] out_bytes_reg;
logic out_done;
// identity is three bytes only; the long unique code is never reachable
assign id_byte = out_bytes_reg == 9'h000 ? ID_VALUE[23:16]
   : out_bytes_reg == 9'h001 ? ID_VALUE[15:8] : ID_VALUE[7:0]; // R02
assign out_byte = info_reg.kind == K_DUAL_ID_READ ? id_byte : src_data;
assign out_next = ocnt_reg == 2'h0 ? out_byte : out_sh_reg;
assign out_done = info_reg.out_max != `DWFCD_UNBOUNDED
   && out_bytes_reg >= info_reg.out_max; // R01 R16
always_ff @(posedge clock) begin
   if (!rstn) begin
      out_sh_reg <= 8'h00;
      ocnt_reg <= 2'h0;
      out_bytes_reg <= 9'h000;
      data_line_zero_o <= 1'b0;
      data_line_one_o <= 1'b0;
      data_line_oe <= 1'b0;
   end else if (!selected) begin
      ocnt_reg <= 2'h0;
      out_bytes_reg <= 9'h000;
      data_line_oe <= 1'b0; // R06 R25
   end else if (sclk_fall && state_reg == ST_OUTPUT) begin
      if (out_done) begin
         data_line_oe <= 1'b0;
      end else begin
         data_line_oe <= 1'b1;
         ocnt_reg <= 2'(ocnt_reg + 2'h1);
         {data_line_one_o, data_line_zero_o} <= out_next[7:6]; // R04
         out_sh_reg <= {out_next[5:0], 2'b00};
         if (ocnt_reg == 2'h3) begin
            out_bytes_reg <= 9'(out_bytes_reg + 9'h001);
         end
      end
   end
end

// byte wanted on output entry and after each byte
always_ff @(posedge clock) begin
   if (!rstn) begin
      rd_req <= '0;
   end else begin
      rd_req.valid <= selected && state_reg != ST_OUTPUT
         && ((sclk_rise && state_reg == ST_DUMMY
            && 4'(dummy_reg + 4'h1) == dummy_cfg)
         || (sclk_rise && byte_done && state_reg == ST_INPUT
            && info_reg.out
            && in_bytes_reg[1:0] == 2'(info_reg.addr_n - 2'h1)
            && !(info_reg.dummy && dummy_cfg != 4'h0))
         || (sclk_rise && byte_done && state_reg == ST_OPCODE
            && accept && info_new.out && info_new.addr_n == 2'h0));
      if (sclk_fall && state_reg == ST_OUTPUT && ocnt_reg == 2'h3) begin
         rd_req.valid <= 1'b1;
      end
      rd_req.kind <= state_reg == ST_OPCODE ? info_new.kind : info_reg.kind;
      rd_req.addr <= addr_reg;
   end
end

////////////////////////////////////////////////////////////////////////////
// execution at deselection
logic exec_ok;
assign exec_ok = state_reg == ST_INPUT && !info_reg.out
   && dib_reg == 2'h0 // R24
   && in_bytes_reg >= info_reg.tot_min
   && in_bytes_reg <= info_reg.tot_max
   && (!info_reg.needs_latch || write_permit_latch); // R26

always_ff @(posedge clock) begin
   if (!rstn) begin
      exec <= '0;
   end else begin
      exec.valid <= cs_rise && exec_ok;
      exec.kind <= info_reg.kind;
      exec.addr <= addr_reg;
   end
end

always_ff @(posedge clock) begin
   if (!rstn) begin
      write_permit_latch <= 1'b0;
      asleep <= 1'b0;
   end else if (cs_rise && exec_ok) begin
      if (info_reg.kind == K_WRITE_LATCH_SET) begin
         write_permit_latch <= 1'b1;
      end else if (info_reg.kind == K_WRITE_LATCH_CLEAR
            || info_reg.needs_latch) begin
         write_permit_latch <= 1'b0; // R26
      end
      if (info_reg.kind == K_SLEEP_ENTER) begin
         asleep <= 1'b1;
      end else if (info_reg.kind == K_SLEEP_EXIT) begin
         asleep <= 1'b0; // R21
      end
   end
end

endmodule // dwfcd_core

/* dv/dwfcd_host.sv */
/* host controller model for the two-wire link of dwfcd_core.
   assumes the bench resolves the line levels from the core's enable. */
`timescale 1ns/1ps
module dwfcd_host (
   output logic sclk, // serial clock, still outside frames
   output logic cs_n, // chip select, active low
   output logic [1:0] drv, // host drive value, line one high
   input wire logic [1:0] wire_lv // resolved line levels
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      drv = 2'h0;
   end
   ////////////////////////////////////////////////////////////////////
   // mode 0: data set while low, taken at the rise
   task automatic dib(input logic [1:0] d);
      drv = d;
      #40 sclk = 1'b1;
      #80 sclk = 1'b0;
      #40;
   endtask
   task automatic start();
      cs_n = 1'b0;
   endtask
   task automatic put(input logic [7:0] v);
      for (int i = 3; i >= 0; i--) dib(v[2*i+:2]);
   endtask
   // released lines flip each period
   task automatic idle(input logic [3:0] n);
      repeat (n) dib(~drv);
   endtask
   task automatic get(input int n, output logic [7:0] v);
      v = 8'h00;
      for (int i = 0; i < n; i++) begin
         v = {v[5:0], wire_lv};
         dib(~drv);
      end
   endtask
   // callers may rise mid-byte, as wr with a tail dibit and the one-dibit id read do
   task automatic stop();
      cs_n = 1'b1;
      drv = ~drv;
      #200;
   endtask
endmodule // dwfcd_host

/* dv/dwfcd_core_asserts.sv */
/* port checker of dwfcd_core.
   assumes it is bound onto the core; serial clock idles low. */
`timescale 1ns/1ps
module dwfcd_core_asserts
   import dwfcd_pkg::*;
(
   input wire logic clock, // system clock
   input wire logic rstn, // sync reset, active low
   input wire logic sclk_pin, // host serial clock
   input wire logic cs_n_pin, // chip select, active low
   input wire logic data_line_zero_o, // line zero drive value
   input wire logic data_line_one_o, // line one drive value
   input wire logic data_line_oe, // lines driven
   input wire logic modify_busy, // modify cycle running
   input wire dwfcd_rd_t rd_req, // byte request
   input wire dwfcd_wr_t wr_byte, // received byte
   input wire dwfcd_exec_t exec, // accepted instruction
   input wire logic write_permit_latch, // permit latch
   input wire logic asleep // sleep state
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   logic wr_kind;
   assign wr_kind = exec.valid && exec.kind inside {K_DUAL_PAGE_PROGRAM,
      K_OTP_PROGRAM, K_SMALL_BLOCK_ERASE, K_BLOCK_ERASE, K_STATUS_WRITE,
      K_WHOLE_ARRAY_ERASE, K_LOCK_WRITE, K_NONVOLATILE_CFG_WRITE,
      K_VOLATILE_CFG_WRITE, K_ENHANCED_CFG_WRITE};
   ////////////////////////////////////////////////////////////////////
   sequence desel_s;
      $rose(cs_n_pin) ##1 cs_n_pin [*5];
   endsequence
   sequence out_step_s;
      $changed({data_line_one_o, data_line_zero_o}) && $past(data_line_oe);
   endsequence
   oe_release_a: assert property (
      desel_s |-> !data_line_oe && !rd_req.valid && !wr_byte.valid)
      else $error("active after deselect");
   out_fall_a: assert property (
      out_step_s |-> !sclk_pin && !$past(sclk_pin, 2))
      else $error("change off serial fall");
   exec_desel_a: assert property (
      exec.valid |-> cs_n_pin && $past(cs_n_pin))
      else $error("issued while selected");
   busy_poll_a: assert property (
      exec.valid && modify_busy |-> exec.kind inside {K_STATUS_READ,
         K_FLAG_STATUS_READ, K_MODIFY_SUSPEND, K_MODIFY_RESUME})
      else $error("non-poll taken while busy");
   latch_need_a: assert property (
      wr_kind |-> $past(write_permit_latch))
      else $error("write without latch");
   latch_drop_a: assert property (
      wr_kind |-> ##[0:3] !write_permit_latch)
      else $error("latch kept after write");
   latch_set_a: assert property (
      exec.valid && exec.kind == K_WRITE_LATCH_SET
         |-> ##[0:3] write_permit_latch)
      else $error("permit latch not set");
   sleep_in_a: assert property (
      exec.valid && exec.kind == K_SLEEP_ENTER |-> ##[0:3] asleep)
      else $error("sleep not entered");
   sleep_out_a: assert property (
      exec.valid && exec.kind == K_SLEEP_EXIT |-> ##[0:3] !asleep)
      else $error("sleep not left");
   sleep_mute_a: assert property (
      asleep |-> !rd_req.valid && !wr_byte.valid)
      else $error("transfer while asleep");
endmodule // dwfcd_core_asserts

bind dwfcd_core dwfcd_core_asserts chk_u (.clock, .rstn, .sclk_pin,
   .cs_n_pin, .data_line_zero_o, .data_line_one_o, .data_line_oe,
   .modify_busy, .rd_req, .wr_byte, .exec, .write_permit_latch, .asleep);

/* dv/test_dwfcd_core.sv */
/* self-checking bench of dwfcd_core with random addresses and data.
   assumes dwfcd_host as far side and the bound checker. */
`timescale 1ns/1ps
module test_dwfcd_core;
   import dwfcd_pkg::*;
   localparam logic [23:0] ID = 24'hC35A69; // arbitrary identity value
   logic clock, rstn, sclk, cs_n, q0, q1, oe, busy, latch, asleep, oe_seen;
   logic [1:0] drv;
   logic [3:0] dcfg;
   logic [7:0] src, b, wd;
   logic [23:0] a;
   logic [7:0] ops [8] = '{8'h5A, 8'h0B, 8'h3B, 8'hBB, 8'hB5, 8'h85,
      8'h65, 8'h70};
   dwfcd_rd_t rd_req;
   dwfcd_wr_t wr_byte;
   dwfcd_exec_t exec, last_ex;
   int n_fail = 0, checks_done = 0, seed = 53744, cyc = 0, n_ex = 0;
   wire [1:0] lv = oe ? {q1, q0} : drv;
   dwfcd_core #(.ID_VALUE(ID)) dut_u (.clock(clock), .rstn(rstn),
      .sclk_pin(sclk), .cs_n_pin(cs_n), .data_line_zero_i(lv[0]),
      .data_line_one_i(lv[1]), .data_line_zero_o(q0),
      .data_line_one_o(q1), .data_line_oe(oe), .modify_busy(busy),
      .dummy_cfg(dcfg), .src_data(src), .rd_req(rd_req),
      .wr_byte(wr_byte), .exec(exec), .write_permit_latch(latch),
      .asleep(asleep));
   dwfcd_host host_u (.sclk(sclk), .cs_n(cs_n), .drv(drv), .wire_lv(lv));
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   function automatic logic [7:0] exp_b(input logic [23:0] x);
      return x[7:0] ^ x[15:8] ^ 8'h3C;
   endfunction
   ////////////////////////////////////////////////////////////////////
   // sample settled outputs; answer byte requests
   always @(posedge clock) begin
      #2 cyc++;
      if (cyc == 60000) begin
         n_fail++;
         summarize();
      end
      if (rd_req.valid) src = exp_b(rd_req.addr) ^ 8'(rd_req.kind);
      if (exec.valid) begin
         n_ex++;
         last_ex = exec;
      end
      if (wr_byte.valid) wd = wr_byte.data;
      if (oe) oe_seen = 1'b1;
   end
   task automatic chk(input logic [31:0] g, e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic open(input logic [7:0] op);
      @(posedge clock);
      #2 n_ex = 0;
      oe_seen = 1'b0;
      host_u.start();
      host_u.put(op);
   endtask
   task automatic close();
      host_u.stop();
      repeat (8) @(posedge clock);
      #2;
   endtask
   task automatic sa(input logic top);
      a = top ? 24'hFFFFFF : 24'($random(seed));
      for (int i = 2; i >= 0; i--) host_u.put(a[8*i+:8]);
   endtask
   task automatic wr(input logic [7:0] op, input int na, nd, x,
         input logic ls);
      if (ls) begin
         open(8'h06);
         close();
      end
      open(op);
      if (na > 0) sa(1'b0);
      for (int i = 0; i < nd; i++) begin
         b = 8'($random(seed));
         host_u.put(b);
      end
      if (x > 0) host_u.dib(2'h1);
      close();
   endtask
   task automatic acc(input logic [7:0] op, input int na, nd,
         input dwfcd_kind_t k, input logic el);
      wr(op, na, nd, 0, 1'b1);
      chk(n_ex, 1);
      chk(32'(last_ex.kind), 32'(k));
      if (na > 0) chk(32'(last_ex.addr), 32'(a));
      if (nd > 0) chk(32'(wd), 32'(b));
      chk(32'(latch), 32'(el));
   endtask
   initial begin
      rstn = 1'b0;
      busy = 1'b0;
      dcfg = 4'h8;
      src = 8'h00;
      repeat (10) @(posedge clock);
      #2 rstn = 1'b1;
      repeat (4) @(posedge clock);
      open(8'hAF);
      host_u.get(1, b);
      close();
      chk(32'(oe), 0);
      chk(32'(b[1:0]), 32'(ID[23:22]));
      open(8'hAF);
      for (int i = 2; i >= 0; i--) begin
         host_u.get(4, b);
         chk(32'(b), 32'(ID[8*i+:8]));
      end
      chk(32'(oe), 0);
      close();
      $display("test id_read done");
      for (int k = 0; k < 4; k++) begin
         dcfg = (k == 3) ? {1'b0, 3'($random(seed))} + 4'h1 : 4'h8;
         open(ops[k]);
         sa(k == 1);
         host_u.idle(dcfg);
         for (int j = 0; j < 2; j++) begin
            host_u.get(4, b);
            chk(32'(b), 32'(exp_b(a + 24'(j)) ^ 8'(k ? K_DUAL_FAST_READ
               : K_PARAM_AREA_READ)));
         end
         close();
      end
      for (int k = 0; k < 4; k++) begin
         open(ops[k+4]);
         host_u.get(8, b);
         chk(32'(oe), 32'(k > 0));
         close();
      end
      $display("test reads done");
      acc(8'h81, 0, 1, K_VOLATILE_CFG_WRITE, 1'b0);
      acc(8'h61, 0, 1, K_ENHANCED_CFG_WRITE, 1'b0);
      acc(8'hB1, 0, 2, K_NONVOLATILE_CFG_WRITE, 1'b0);
      acc(8'hE5, 3, 1, K_LOCK_WRITE, 1'b0);
      acc(8'h02, 3, 1, K_DUAL_PAGE_PROGRAM, 1'b0);
      acc(8'hA2, 3, 2, K_DUAL_PAGE_PROGRAM, 1'b0);
      acc(8'hD2, 3, 3, K_DUAL_PAGE_PROGRAM, 1'b0);
      acc(8'h20, 3, 0, K_SMALL_BLOCK_ERASE, 1'b0);
      acc(8'hC7, 0, 0, K_WHOLE_ARRAY_ERASE, 1'b0);
      acc(8'h50, 0, 0, K_FLAG_STATUS_CLEAR, 1'b1);
      acc(8'h04, 0, 0, K_WRITE_LATCH_CLEAR, 1'b0);
      wr(8'h81, 0, 1, 0, 1'b0);
      chk(n_ex, 0);
      wr(8'h81, 0, 1, 1, 1'b1);
      chk(n_ex, 0);
      wr(8'hB1, 0, 1, 0, 1'b1);
      chk(n_ex, 0);
      wr(8'hE5, 3, 0, 0, 1'b1);
      chk(n_ex, 0);
      wr(8'hFF, 0, 0, 0, 1'b0);
      chk(n_ex, 0);
      $display("test writes done");
      busy = 1'b1;
      open(8'hAF);
      host_u.get(4, b);
      close();
      chk(32'(oe_seen), 0);
      wr(8'h75, 0, 0, 0, 1'b0);
      chk(n_ex, 1);
      busy = 1'b0;
      wr(8'hB9, 0, 0, 0, 1'b0);
      chk(32'(asleep), 1);
      wr(8'h06, 0, 0, 0, 1'b0);
      chk(n_ex, 0);
      wr(8'hAB, 0, 0, 0, 1'b0);
      chk(32'(asleep), 0);
      $display("test busy_sleep done");
      summarize();
   end
endmodule // test_dwfcd_core
